// *** rtl/mph_defines.svh ***
// Timing, priority and framing constants of the multiphase poll host
`ifndef MPH_DEFINES_SVH
`define MPH_DEFINES_SVH

// ---------------------------------------------------------------------
// Clock and derived rates
// ---------------------------------------------------------------------
`define MPH_CLK_HZ        20000000
`define MPH_TICK_HZ       4000
`define MPH_RTC_HZ        1
`define MPH_AFE_BAUD      57600
`define MPH_GUI_BAUD      9600
`define MPH_TICK_CYCLES   (`MPH_CLK_HZ / `MPH_TICK_HZ)
`define MPH_RTC_CYCLES    (`MPH_CLK_HZ / `MPH_RTC_HZ)
`define MPH_AFE_BIT_CYC   (`MPH_CLK_HZ / `MPH_AFE_BAUD)
`define MPH_GUI_BIT_CYC   (`MPH_CLK_HZ / `MPH_GUI_BAUD)

// ---------------------------------------------------------------------
// Interrupt priority codes, lower wins
// ---------------------------------------------------------------------
`define MPH_PRIO_TICK     8'h20
`define MPH_PRIO_READY    8'h40
`define MPH_PRIO_PKT      8'h60
`define MPH_PRIO_GUI      8'h80
`define MPH_PRIO_RTC      8'h80

// ---------------------------------------------------------------------
// Polling defaults; gap, ready delay and timeout counted in tick periods
// ---------------------------------------------------------------------
`define MPH_PKT_LEN       16
`define MPH_POLL_GAP      16
`define MPH_READY_DELAY   4
`define MPH_TIMEOUT       24
`define MPH_CMD_READ      8'h01
`define MPH_ROUTE_NONE    3'h0

`endif

// *** rtl/mph_pkg.sv ***
// Types shared by the multiphase poll host
package mph_pkg;

   typedef enum logic [1:0] {
      MPH_IDLE = 2'b00,
      MPH_SEND = 2'b01,
      MPH_WAIT = 2'b10
   } mph_poll_e;

   // Source indices of the pending interrupt vector
   typedef enum logic [2:0] {
      MPH_SRC_TICK  = 3'h0,
      MPH_SRC_READY = 3'h1,
      MPH_SRC_PKT   = 3'h2,
      MPH_SRC_GUI   = 3'h3,
      MPH_SRC_RTC   = 3'h4
   } mph_src_e;

   typedef struct packed {
      logic       valid;
      mph_src_e   src;
      logic [7:0] code;
   } mph_irq_s;

endpackage : mph_pkg

// *** rtl/mph_pkt_mem.sv ***
// Packet buffer with registered read data
`timescale 1ns/10ps
`default_nettype none

module mph_pkt_mem #(
   parameter int DW    = 8,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock
   input  wire logic          core_clk,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // Read port
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);

   logic [DW-1:0] mem_q [DEPTH];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge core_clk) begin
      rd_data <= mem_q[rd_addr];
   end

endmodule : mph_pkt_mem

`default_nettype wire

// *** rtl/mph_uart.sv ***
// 8N1 serial transmitter and receiver
`timescale 1ns/10ps
`default_nettype none

module mph_uart #(
   parameter int CLKS_PER_BIT = 347
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // Transmit side
   input  wire logic       tx_start,
   input  wire logic [7:0] tx_data,
   output logic            tx_busy,
   output logic            txd,
   // Receive side, line already synchronised
   input  wire logic       rxd,
   output logic            rx_valid,
   output logic [7:0]      rx_data
);

   localparam int CW = $clog2(CLKS_PER_BIT + 1);

   logic [CW-1:0] tx_cnt_q;
   logic [3:0]    tx_bit_q;
   logic [9:0]    tx_sh_q;
   logic [CW-1:0] rx_cnt_q;
   logic [3:0]    rx_bit_q;
   logic [7:0]    rx_sh_q;
   logic          rx_act_q;

   // ------------------------------------------------------------------
   // Transmitter: start, eight data bits LSB first, one stop
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         tx_busy  <= 1'b0;
         txd      <= 1'b1;
         tx_cnt_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q  <= '1;
      end else if (!tx_busy) begin
         if (tx_start) begin
            tx_busy  <= 1'b1;
            tx_sh_q  <= {1'b1, tx_data, 1'b0};
            txd      <= 1'b0;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
         end
      end else if (tx_cnt_q == CW'(CLKS_PER_BIT - 1)) begin
         tx_cnt_q <= '0;
         tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
         if (tx_bit_q == 4'h9) begin
            tx_busy <= 1'b0;
            txd     <= 1'b1;
         end else begin
            tx_bit_q <= tx_bit_q + 4'h1;
            txd      <= tx_sh_q[1];
         end
      end else begin
         tx_cnt_q <= tx_cnt_q + 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Receiver: sample mid bit, drop frames with a bad start or stop
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rx_act_q <= 1'b0;
         rx_cnt_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q  <= '0;
         rx_valid <= 1'b0;
         rx_data  <= '0;
      end else begin
         rx_valid <= 1'b0;
         if (!rx_act_q) begin
            if (!rxd) begin
               rx_act_q <= 1'b1;
               rx_cnt_q <= CW'(CLKS_PER_BIT / 2);
               rx_bit_q <= '0;
            end
         end else if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
         end else begin
            rx_cnt_q <= CW'(CLKS_PER_BIT - 1);
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0) begin
               // Glitch, not a start bit
               if (rxd) rx_act_q <= 1'b0;
            end else if (rx_bit_q == 4'h9) begin
               rx_act_q <= 1'b0;
               if (rxd) begin
                  rx_valid <= 1'b1;
                  rx_data  <= rx_sh_q;
               end
            end else begin
               rx_sh_q <= {rxd, rx_sh_q[7:1]};
            end
         end
      end
   end

endmodule : mph_uart

`default_nettype wire

// *** rtl/mph_poll_host.sv ***
// Poll host collecting readings from three phase front ends
//
// Operation
// - A 4000 Hz tick accumulates active power into energy and ages timeouts.
// - Requests to different phases are spaced so each reply fits between.
// - A fixed delay separates a ready strobe from the matching request.
// - At most one phase receive line is routed to the receiver at once.
// - Commands go to all front ends; only the addressed line is routed.
// - In two-channel mode idle phase lines act as interrupt inputs.
// - In two-channel mode a line is routed only while its reply is awaited.
// - A good reply or a timeout returns the line to interrupt use.
// - Three separate receive lines, one per phase A, B and C.
// - Received bytes fill consecutive memory locations until a packet ends.
// - A completed packet raises an interrupt at once.
// - Interrupts rank by code, lower wins: 0x20, 0x40, 0x60, 0x80, 0x80.
// - The ready-pin interrupt names the phase that has new readings.
// - GUI link is 8N1 at 9600 baud, interrupting on empty and on receive.
// - A real-time interrupt fires each second and advances the time.
// - Every second real-time tick triggers a display update.
// - The front-end link is 8N1 at 57,600 baud.
`timescale 1ns/10ps
`default_nettype none
`include "mph_defines.svh"

module mph_poll_host #(
   parameter int TICK_CYCLES   = `MPH_TICK_CYCLES,
   parameter int RTC_CYCLES    = `MPH_RTC_CYCLES,
   parameter int PKT_LEN       = `MPH_PKT_LEN,
   parameter int POLL_GAP      = `MPH_POLL_GAP,
   parameter int READY_DELAY   = `MPH_READY_DELAY,
   parameter int TIMEOUT_TICKS = `MPH_TIMEOUT,
   parameter int AW            = $clog2(PKT_LEN)
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rstn,
   // Mode
   input  wire logic              two_channel_mode,
   // Front-end link pins
   input  wire logic [2:0]        afe_rx_line,
   output logic                   afe_txd,
   output logic [2:0]             rx_route_select,
   // Packet readout
   input  wire logic [AW-1:0]     pkt_rd_addr,
   output logic [7:0]             pkt_rd_data,
   output logic [1:0]             pkt_phase,
   // Energy
   input  wire logic [31:0]       active_power,
   output logic [47:0]            active_energy,
   // GUI link
   input  wire logic              gui_rxd,
   output logic                   gui_txd,
   input  wire logic              gui_tx_valid,
   input  wire logic [7:0]        gui_tx_data,
   output logic                   gui_tx_busy,
   output logic [7:0]             gui_rx_data,
   // Time and display
   output logic [31:0]            rtc_seconds,
   output logic                   display_update,
   // Interrupt presentation
   input  wire logic              irq_ack,
   output mph_pkg::mph_irq_s      irq_out,
   output logic [1:0]             ready_phase,
   output logic                   reply_timeout
);

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int RW = $clog2(RTC_CYCLES + 1);
   localparam int GW = $clog2(POLL_GAP + TIMEOUT_TICKS + READY_DELAY + 2);

   // ------------------------------------------------------------------
   // Pin synchronisers and strobe edge detection
   // ------------------------------------------------------------------
   logic [2:0] line_meta_q;
   logic [2:0] line_sync_q;
   logic [2:0] line_prev_q;
   logic [2:0] strobe_fall;
   logic       gui_meta_q;
   logic       gui_sync_q;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_phase_line
         always_ff @(posedge core_clk) begin
            if (!rstn) begin
               line_meta_q[gi] <= 1'b1;
               line_sync_q[gi] <= 1'b1;
               line_prev_q[gi] <= 1'b1;
            end else begin
               line_meta_q[gi] <= afe_rx_line[gi];
               line_sync_q[gi] <= line_meta_q[gi];
               line_prev_q[gi] <= line_sync_q[gi];
            end
         end
         // Only an unrouted line counts as an interrupt input
         assign strobe_fall[gi] = two_channel_mode
                                  && !rx_route_select[gi]
                                  && line_prev_q[gi]
                                  && !line_sync_q[gi];
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         gui_meta_q <= 1'b1;
         gui_sync_q <= 1'b1;
      end else begin
         gui_meta_q <= gui_rxd;
         gui_sync_q <= gui_meta_q;
      end
   end

   // ------------------------------------------------------------------
   // Tick timer and energy
   // ------------------------------------------------------------------
   logic [TW-1:0] tick_cnt_q;
   logic          tick_q;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q     <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         active_energy <= '0;
      end else if (tick_q) begin
         active_energy <= active_energy + {16'h0, active_power};
      end
   end

   // ------------------------------------------------------------------
   // Ready strobes
   // ------------------------------------------------------------------
   logic [2:0] ready_pend_q;
   logic [1:0] pick_ph;
   logic       pick_any;

   always_comb begin
      pick_any = 1'b1;
      if (ready_pend_q[0]) begin
         pick_ph = 2'h0;
      end else if (ready_pend_q[1]) begin
         pick_ph = 2'h1;
      end else if (ready_pend_q[2]) begin
         pick_ph = 2'h2;
      end else begin
         pick_ph  = 2'h0;
         pick_any = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Poll sequencer
   // ------------------------------------------------------------------
   mph_pkg::mph_poll_e state_q;
   logic [GW-1:0]      gap_q;
   logic [GW-1:0]      wait_q;
   logic [1:0]         next_ph_q;
   logic [AW-1:0]      wr_addr_q;
   logic               send_q;
   logic               pkt_done_q;
   logic               afe_busy;
   logic               afe_rx_valid;
   logic [7:0]         afe_rx_data;
   logic               routed_line;
   logic               go_poll;

   assign routed_line = |(rx_route_select & line_sync_q);
   // Gap elapsed and, for strobe-driven polls, the settle delay too
   assign go_poll = (state_q == mph_pkg::MPH_IDLE)
                    && (gap_q >= GW'(POLL_GAP))
                    && (!two_channel_mode
                        || (pick_any
                            && wait_q >= GW'(READY_DELAY)));

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_q         <= mph_pkg::MPH_IDLE;
         rx_route_select <= `MPH_ROUTE_NONE;
         gap_q           <= GW'(POLL_GAP);
         wait_q          <= '0;
         next_ph_q       <= 2'h0;
         pkt_phase       <= 2'h0;
         wr_addr_q       <= '0;
         send_q          <= 1'b0;
         pkt_done_q      <= 1'b0;
         reply_timeout   <= 1'b0;
         ready_pend_q    <= '0;
      end else begin
         send_q        <= 1'b0;
         pkt_done_q    <= 1'b0;
         reply_timeout <= 1'b0;
         if (tick_q && gap_q != '1) gap_q <= gap_q + 1'b1;
         if (!pick_any) begin
            wait_q <= '0;
         end else if (tick_q && wait_q != '1) begin
            wait_q <= wait_q + 1'b1;
         end
         ready_pend_q <= ready_pend_q | strobe_fall;
         case (state_q)
            mph_pkg::MPH_IDLE: begin
               if (go_poll) begin
                  pkt_phase <= two_channel_mode ? pick_ph : next_ph_q;
                  if (two_channel_mode) begin
                     // Strobe arriving now on the same phase is kept
                     ready_pend_q <= (ready_pend_q
                                      & ~(3'h1 << pick_ph)) | strobe_fall;
                  end
                  next_ph_q <= (next_ph_q == 2'h2) ? 2'h0
                               : next_ph_q + 2'h1;
                  send_q    <= 1'b1;
                  state_q   <= mph_pkg::MPH_SEND;
               end
            end
            mph_pkg::MPH_SEND: begin
               // Route only once the broadcast byte is out
               if (!send_q && !afe_busy) begin
                  rx_route_select <= 3'h1 << pkt_phase;
                  wr_addr_q       <= '0;
                  gap_q           <= '0;
                  state_q         <= mph_pkg::MPH_WAIT;
               end
            end
            mph_pkg::MPH_WAIT: begin
               if (afe_rx_valid) begin
                  wr_addr_q <= wr_addr_q + 1'b1;
                  if (wr_addr_q == AW'(PKT_LEN - 1)) begin
                     pkt_done_q      <= 1'b1;
                     rx_route_select <= `MPH_ROUTE_NONE;
                     state_q         <= mph_pkg::MPH_IDLE;
                  end
               end else if (gap_q >= GW'(TIMEOUT_TICKS)) begin
                  reply_timeout   <= 1'b1;
                  rx_route_select <= `MPH_ROUTE_NONE;
                  state_q         <= mph_pkg::MPH_IDLE;
               end
            end
            default: begin
               state_q         <= mph_pkg::MPH_IDLE;
               rx_route_select <= `MPH_ROUTE_NONE;
            end
         endcase
      end
   end

   mph_uart #(
      .CLKS_PER_BIT (`MPH_AFE_BIT_CYC)
   ) u_afe_serial_port (
      .core_clk (core_clk),
      .rstn     (rstn),
      .tx_start (send_q),
      .tx_data  (`MPH_CMD_READ),
      .tx_busy  (afe_busy),
      .txd      (afe_txd),
      .rxd      (routed_line | ~(|rx_route_select)),
      .rx_valid (afe_rx_valid),
      .rx_data  (afe_rx_data)
   );

   mph_pkt_mem #(
      .DW    (8),
      .DEPTH (PKT_LEN)
   ) u_pkt_mem (
      .core_clk (core_clk),
      .wr_en    (afe_rx_valid && state_q == mph_pkg::MPH_WAIT),
      .wr_addr  (wr_addr_q),
      .wr_data  (afe_rx_data),
      .rd_addr  (pkt_rd_addr),
      .rd_data  (pkt_rd_data)
   );

   // ------------------------------------------------------------------
   // GUI link
   // ------------------------------------------------------------------
   logic gui_rx_valid;
   logic gui_busy_prev_q;
   logic gui_start;

   assign gui_start = gui_tx_valid && !gui_tx_busy;

   mph_uart #(
      .CLKS_PER_BIT (`MPH_GUI_BIT_CYC)
   ) u_gui_serial_port (
      .core_clk (core_clk),
      .rstn     (rstn),
      .tx_start (gui_start),
      .tx_data  (gui_tx_data),
      .tx_busy  (gui_tx_busy),
      .txd      (gui_txd),
      .rxd      (gui_sync_q),
      .rx_valid (gui_rx_valid),
      .rx_data  (gui_rx_data)
   );

   always_ff @(posedge core_clk) begin
      if (!rstn) gui_busy_prev_q <= 1'b0;
      else       gui_busy_prev_q <= gui_tx_busy;
   end

   // ------------------------------------------------------------------
   // Real-time clock and display
   // ------------------------------------------------------------------
   logic [RW-1:0] rtc_cnt_q;
   logic          rtc_tick_q;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rtc_cnt_q      <= '0;
         rtc_tick_q     <= 1'b0;
         rtc_seconds    <= '0;
         display_update <= 1'b0;
      end else begin
         rtc_tick_q     <= 1'b0;
         display_update <= 1'b0;
         if (rtc_cnt_q == RW'(RTC_CYCLES - 1)) begin
            rtc_cnt_q   <= '0;
            rtc_tick_q  <= 1'b1;
            rtc_seconds <= rtc_seconds + 32'h1;
            // Odd count before increment means every second tick
            display_update <= rtc_seconds[0];
         end else begin
            rtc_cnt_q <= rtc_cnt_q + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Interrupt ranking; a set in the ack cycle survives
   // ------------------------------------------------------------------
   logic [4:0]         irq_pend_q;
   logic [4:0]         irq_set;
   logic [4:0]         irq_clr;
   mph_pkg::mph_irq_s  irq_win;

   assign irq_set = {rtc_tick_q,
                     gui_rx_valid || (gui_busy_prev_q && !gui_tx_busy),
                     pkt_done_q,
                     |strobe_fall,
                     tick_q};

   always_comb begin
      irq_win = '0;
      if (irq_pend_q[0]) begin
         irq_win = {1'b1, mph_pkg::MPH_SRC_TICK, `MPH_PRIO_TICK};
      end else if (irq_pend_q[1]) begin
         irq_win = {1'b1, mph_pkg::MPH_SRC_READY, `MPH_PRIO_READY};
      end else if (irq_pend_q[2]) begin
         irq_win = {1'b1, mph_pkg::MPH_SRC_PKT, `MPH_PRIO_PKT};
      end else if (irq_pend_q[3]) begin
         irq_win = {1'b1, mph_pkg::MPH_SRC_GUI, `MPH_PRIO_GUI};
      end else if (irq_pend_q[4]) begin
         irq_win = {1'b1, mph_pkg::MPH_SRC_RTC, `MPH_PRIO_RTC};
      end
   end

   assign irq_clr = (irq_ack && irq_out.valid)
                    ? (5'h1 << irq_out.src) : 5'h0;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         irq_pend_q <= '0;
         irq_out    <= '0;
      end else begin
         irq_pend_q <= (irq_pend_q & ~irq_clr) | irq_set;
         irq_out    <= irq_win;
         if (irq_clr != 5'h0) irq_out <= '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ready_phase <= 2'h0;
      end else if (strobe_fall[0]) begin
         ready_phase <= 2'h0;
      end else if (strobe_fall[1]) begin
         ready_phase <= 2'h1;
      end else if (strobe_fall[2]) begin
         ready_phase <= 2'h2;
      end
   end

endmodule : mph_poll_host

`default_nettype wire

// *** verification/mph_poll_host_monitor.sv ***
// Port assertions for the poll host
`timescale 1ns/10ps
`default_nettype none
module mph_poll_host_monitor (
   // Watched ports
   input wire logic              core_clk,
   input wire logic              rstn,
   input wire logic              afe_txd,
   input wire logic [2:0]        rx_route_select,
   input wire logic              gui_tx_valid,
   input wire logic              gui_tx_busy,
   input wire logic [31:0]       rtc_seconds,
   input wire logic              display_update,
   input wire logic              irq_ack,
   input wire mph_pkg::mph_irq_s irq_out,
   input wire logic              reply_timeout
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   function automatic logic [7:0] rank(logic [2:0] s);
      return s == 3'h0 ? 8'h20 : s == 3'h1 ? 8'h40 :
             s == 3'h2 ? 8'h60 : 8'h80;
   endfunction : rank
   route_one_a: assert property ($onehot0(rx_route_select))
      else $error("two lines routed");
   route_quiet_a: assert property (rx_route_select != 3'h0 |-> afe_txd)
      else $error("command sent while routed");
   irq_rank_a: assert property (
      irq_out.valid |-> irq_out.code == rank(irq_out.src))
      else $error("wrong irq code");
   ack_clear_a: assert property (irq_out.valid && irq_ack |=> !irq_out.valid)
      else $error("ack did not clear");
   disp_even_a: assert property (display_update |-> !rtc_seconds[0])
      else $error("display update on odd second");
   rtc_step_a: assert property (
      $changed(rtc_seconds) |-> rtc_seconds == $past(rtc_seconds) + 32'h1)
      else $error("seconds skipped");
   tmo_free_a: assert property (
      reply_timeout |-> ##[0:1] rx_route_select == 3'h0)
      else $error("line kept after timeout");
   gui_take_a: assert property (
      gui_tx_valid && !gui_tx_busy |=> gui_tx_busy)
      else $error("gui byte not taken");
   cover property ($rose(|rx_route_select));
   cover property (reply_timeout);
   cover property (display_update);
   cover property (irq_out.valid && irq_out.src == mph_pkg::MPH_SRC_PKT);
endmodule : mph_poll_host_monitor
bind mph_poll_host mph_poll_host_monitor mph_poll_host_monitor_i (
   .core_clk(core_clk), .rstn(rstn), .afe_txd(afe_txd),
   .rx_route_select(rx_route_select), .gui_tx_valid(gui_tx_valid),
   .gui_tx_busy(gui_tx_busy), .rtc_seconds(rtc_seconds),
   .display_update(display_update), .irq_ack(irq_ack),
   .irq_out(irq_out), .reply_timeout(reply_timeout));
`default_nettype wire

// *** verification/mph_afe_model.sv ***
// Behavioural model of the three phase front ends
`timescale 1ns/10ps
`default_nettype none
module mph_afe_model #(
   parameter int BIT    = 347,
   parameter int STROBE = 100
) (
   // Host side
   input wire logic       core_clk,
   input wire logic       cmd_line,
   output var logic [2:0] fe_txd
);
   int nbytes [3] = '{2, 2, 2};
   // Released lines sit at the pull-up level
   initial fe_txd = 3'h7;
   task automatic send(int p);
      logic [9:0] fr;
      for (int b = 0; b < nbytes[p]; b++) begin
         fr = {1'b1, 8'(p * 16 + b), 1'b0};
         for (int k = 0; k < 10; k++) begin
            fe_txd[p] <= fr[k];
            repeat (BIT) @(posedge core_clk);
         end
      end
   endtask : send
   // Strobe shortened from milliseconds to keep the run short
   task automatic strobe(int p);
      fe_txd[p] <= 1'b0;
      repeat (STROBE) @(posedge core_clk);
      fe_txd[p] <= 1'b1;
   endtask : strobe
   // Replies run detached, so a command right after a reply is not missed
   always begin
      @(negedge cmd_line);
      repeat (10 * BIT + 700) @(posedge core_clk);
      fork send(0); send(1); send(2); join_none
   end
endmodule : mph_afe_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the poll host
`timescale 1ns/10ps
`default_nettype none
`include "mph_defines.svh"
module tb;
   localparam int TK = 50;
   localparam int TMO = 200;
   localparam int CMD = 10 * `MPH_AFE_BIT_CYC;
   logic core_clk, rstn, mode, txv, ack, txd, busy, disp, tmo;
   logic [2:0] line, route;
   logic [0:0] ra;
   logic [7:0] rd, txb, grx;
   logic [1:0] ph, rph;
   logic [31:0] secs;
   logic [47:0] energy;
   wire logic gline;
   mph_pkg::mph_irq_s irq;
   int miscompares = 0, checks_done = 0, n_pkt = 0, n_rdy = 0, n_gui = 0;
   mph_poll_host #(.TICK_CYCLES(TK), .RTC_CYCLES(2000), .PKT_LEN(2),
      .TIMEOUT_TICKS(TMO)) mph_poll_host_i (
      .core_clk(core_clk), .rstn(rstn), .two_channel_mode(mode),
      .afe_rx_line(line), .afe_txd(txd), .rx_route_select(route),
      .pkt_rd_addr(ra), .pkt_rd_data(rd), .pkt_phase(ph),
      .active_power(32'h3), .active_energy(energy), .gui_rxd(gline),
      .gui_txd(gline), .gui_tx_valid(txv), .gui_tx_data(txb),
      .gui_tx_busy(busy), .gui_rx_data(grx), .rtc_seconds(secs),
      .display_update(disp), .irq_ack(ack), .irq_out(irq),
      .ready_phase(rph), .reply_timeout(tmo));
   mph_afe_model afe_i (.core_clk(core_clk), .cmd_line(txd), .fe_txd(line));
   initial begin
      core_clk = 0;
      forever #25 core_clk = ~core_clk;
   end
   // Software stand-in: count a source at the edge whose ack clears it,
   // since a higher rank may replace the presented source before the ack
   always @(posedge core_clk) begin
      ack <= irq.valid && !ack;
      if (irq.valid === 1'b1 && ack === 1'b1) begin
         n_pkt += irq.src == mph_pkg::MPH_SRC_PKT;
         n_rdy += irq.src == mph_pkg::MPH_SRC_READY;
         n_gui += irq.src == mph_pkg::MPH_SRC_GUI;
      end
   end
   task automatic chk(logic [47:0] got, logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic wait_pkt(int n);
      for (int i = 0; i < 12000 && n_pkt == n; i++) @(posedge core_clk);
      chk(48'(n_pkt - n), 48'h1);
      chk(route, 48'h0);
   endtask : wait_pkt
   task automatic t_poll(int p, logic md);
      int n;
      n = n_pkt;
      for (int i = 0; i < 9000 && route == 3'h0; i++) @(posedge core_clk);
      mode <= md;
      chk(route, 48'(1 << p));
      chk(ph, 48'(p));
      wait_pkt(n);
      for (int b = 0; b < 2; b++) begin
         ra <= 1'(b);
         repeat (2) @(posedge core_clk);
         chk(rd, 48'(p * 16 + b));
      end
      $display("poll of phase %0d done", p);
   endtask : t_poll
   task automatic t_timeout;
      int c = 0;
      afe_i.nbytes[2] = 1;
      for (int i = 0; i < 9000 && route == 3'h0; i++) @(posedge core_clk);
      chk(route, 48'h4);
      while (tmo !== 1'b1 && c < 12000) begin
         @(posedge core_clk);
         c++;
      end
      chk(48'(c >= (TMO - 1) * TK && c <= (TMO + 1) * TK), 48'h1);
      @(posedge core_clk);
      chk(route, 48'h0);
      // Replying neighbours would look like strobes in two-channel mode
      afe_i.nbytes = '{2, 0, 0};
      $display("timeout test done");
   endtask : t_timeout
   task automatic t_ready;
      int c = 0;
      int n = n_rdy;
      int m = n_pkt;
      afe_i.nbytes = '{0, 2, 0};
      fork afe_i.strobe(1); join_none
      while (route == 3'h0 && c < 9000) begin
         @(posedge core_clk);
         c++;
      end
      chk(48'(n_rdy - n), 48'h1);
      chk(rph, 48'h1);
      chk(route, 48'h2);
      chk(48'(c >= (`MPH_READY_DELAY - 1) * TK + CMD), 48'h1);
      chk(48'(c <= (`MPH_READY_DELAY + 2) * TK + CMD), 48'h1);
      wait_pkt(m);
      $display("ready strobe test done");
   endtask : t_ready
   task automatic t_gui;
      int n = n_gui;
      logic [47:0] e0;
      logic [31:0] s0;
      e0 = energy;
      s0 = secs;
      // One real-time period spans forty ticks
      repeat (40 * TK) @(posedge core_clk);
      chk(energy - e0, 48'h78);
      chk(48'(secs - s0), 48'h1);
      txb <= 8'ha5;
      txv <= 1'b1;
      for (int i = 0; i < 10 && busy !== 1'b1; i++) @(posedge core_clk);
      txv <= 1'b0;
      for (int i = 0; i < 25000 && n_gui - n < 2; i++) @(posedge core_clk);
      chk(48'(n_gui - n), 48'h2);
      chk(grx, 48'ha5);
      $display("gui loopback test done");
   endtask : t_gui
   initial begin
      repeat (100000) @(posedge core_clk);
      miscompares++;
      finish_test;
   end
   initial begin
      {rstn, mode, txv, ra, txb} = '0;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      t_poll(0, 1'b0);
      t_poll(1, 1'b0);
      t_timeout;
      t_poll(0, 1'b1);
      t_ready;
      t_gui;
      finish_test;
   end
endmodule : tb
`default_nettype wire
